// ---- src/obc_decoder.sv ----
// Option byte decoder with AHB-Lite access in programming mode
//
// How it works
// - Byte0 bit4 low turns undervoltage detector on
// - Byte0 bit3 low enables clock doubler
// - Byte0 bits2:1 select 64, 44, 32 pins
// - Unbonded pads get input with pull-up
// - Byte0 bit0 low blocks readout and writes
// - Erase under protection wipes user memory first
// - Byte1 bit7 remaps timer and serial pins
// - Byte1 bit6 moves capture 2 pin
// - Byte1 bits5:4 select main clock source
// - Byte1 bits3:2 select oscillator range
// - Byte1 bit0 picks 4096 or 256 delay
// - Byte0 bit7 resets on halt with watchdog
// - Byte0 bit6 picks hardware or software watchdog
// - Bytes reachable only in programming mode
`timescale 1ns/1ns
`default_nettype none
module obc_decoder
   import obc_pkg::*;
(
   input  wire logic        hclk,                         // Bus clock
   input  wire logic        hresetn,                      // Async reset, active low
   input  wire logic        hsel,                         // Slave select
   input  wire logic [7:0]  haddr,                        // Byte address
   input  wire logic [1:0]  htrans,                       // Transfer type
   input  wire logic        hwrite,                       // Write when high
   input  wire logic [2:0]  hsize,                        // Transfer size
   input  wire logic [31:0] hwdata,                       // Write data
   input  wire logic        hready,                       // Bus ready in
   output logic      [31:0] hrdata,                       // Read data
   output logic             hreadyout,                    // Slave ready
   output logic             hresp,                        // Always OKAY
   input  wire logic        prog_mode,                    // Programming mode pin
   input  wire logic        halt_req,                     // Pulse on halt exit
   output logic             undervoltage_detector_on,     // Detector enable
   output logic             pll_x2_enable,                // Clock doubler on
   output logic      [1:0]  package_select,               // Package code
   output logic      [47:0] unbonded_pad_pullup,          // Pull-up per pad
   output logic             readout_protect_n,            // Low: protected
   output logic             flash_write_block,            // Blocks flash writes
   output logic             alt_function_remap,           // Timer/serial remap
   output logic             capture2_on_alt_pin,          // Capture 2 on alt pin
   output logic      [1:0]  clock_source_select,          // Main clock source
   output logic      [1:0]  resonator_range_select,       // Oscillator range
   output logic             reset_delay_select,           // High: short delay
   output logic             delay_busy,                   // Reset/halt delay runs
   output logic             watchdog_reset_on_halt,       // Reset on halt
   output logic             watchdog_software_enable_mode,// Software watchdog
   output logic             user_mem_erase,               // Pulse: wipe user memory
   output logic             in_circuit_programming_mode   // Internal IN_CIRCUIT_PROGRAMMING_MODE clock
);
   import obc_pkg::*;

   typedef enum {OBC_IDLE, OBC_WIPE} obc_state_e;

   // Non-volatile byte images, latched decoded copies and bus phase state
   logic [7:0]  ob0_r = OB0_DEFAULT;  // Shipped content at power up
   logic [7:0]  ob1_r = OB1_DEFAULT;  // Shipped content at power up
   logic [7:0]  lat0_r;
   logic [7:0]  lat1_r;
   logic        sampled_r;
   logic        wr_pend_r;
   logic [7:0]  wr_addr_r;
   logic        erase_pend_r;
   logic [6:0]  wipe_cnt_r;
   obc_state_e  state_r;
   obc_state_e  state_nxt;
   logic [31:0] hrdata_r;
   logic        first_r;

   // Address phase decode
   wire         acc_valid = hsel & hready & htrans[1];
   wire         acc_write = acc_valid & hwrite;
   wire         acc_read  = acc_valid & ~hwrite;
   wire         ob_addr   = (haddr == REG_OB0) | (haddr == REG_OB1);
   wire         protected_now = ~ob0_r[OB0_RDP_N_BIT];
   wire         wiping    = (state_r == OBC_WIPE);

   // Programming mode gate on the option bytes
   function automatic logic ob_open(input logic pm, input logic [7:0] a);
      ob_open = pm & ((a == REG_OB0) | (a == REG_OB1));
   endfunction

   // Register read mux; option bytes read zero outside programming mode
   wire [31:0]  rd_val =
      (haddr == REG_OB0)    ? (prog_mode ? {24'h000000, ob0_r} : 32'h0000_0000) :
      (haddr == REG_OB1)    ? (prog_mode ? {24'h000000, ob1_r} : 32'h0000_0000) :
      (haddr == REG_CTRL)   ? {30'h0000_0000, erase_pend_r, prog_mode} :
      (haddr == REG_STATUS) ? {28'h000_0000, delay_busy, wiping, sampled_r,
                               protected_now} :
      (haddr == REG_DECODE) ? {16'h0000, lat1_r, lat0_r} :
                              32'h0000_0000;

   // Address phase capture and read data; bus never waits
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         hrdata_r  <= 32'h0000_0000;
      end
      else
      begin
         wr_pend_r <= acc_write;
         wr_addr_r <= haddr;
         if (acc_read)
            hrdata_r <= rd_val;
      end
   end

   // Data phase write; protection blocks byte writes, erase comes first
   wire         wr_ob0   = wr_pend_r & (wr_addr_r == REG_OB0) & ob_open(prog_mode, wr_addr_r);
   wire         wr_ob1   = wr_pend_r & (wr_addr_r == REG_OB1) & ob_open(prog_mode, wr_addr_r);
   wire         wr_ctrl  = wr_pend_r & (wr_addr_r == REG_CTRL) & prog_mode;
   wire         erase_rq = wr_ctrl & hwdata[CTRL_ERASE_BIT];
   wire         wipe_done = wiping & (wipe_cnt_r == 7'h00);

   // Erase sequence: wipe user memory while protected, then erase bytes
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         OBC_IDLE: if (erase_rq & protected_now) state_nxt = OBC_WIPE;
         OBC_WIPE: if (wipe_done) state_nxt = OBC_IDLE;
         default:  state_nxt = OBC_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_r      <= OBC_IDLE;
         wipe_cnt_r   <= 7'h00;
         erase_pend_r <= 1'b0;
      end
      else
      begin
         state_r      <= state_nxt;
         erase_pend_r <= (state_nxt == OBC_WIPE);
         if (state_r == OBC_IDLE && state_nxt == OBC_WIPE)
            wipe_cnt_r <= 7'(ERASE_CYCLES - 1);
         else if (wipe_cnt_r != 7'h00)
            wipe_cnt_r <= wipe_cnt_r - 7'h01;
      end
   end
   assign user_mem_erase = (state_r == OBC_IDLE) & (state_nxt == OBC_WIPE);

   // Option byte storage; not cleared by hresetn, like flash, so a new
   // image only reaches the controls at the next reset sampling
   always_ff @(posedge hclk)
   begin
      if (wipe_done | (erase_rq & ~protected_now & ~wiping))
      begin
         ob0_r <= OB_ERASED;
         ob1_r <= OB_ERASED;
      end
      else if (~protected_now)
      begin
         if (wr_ob0)
            ob0_r <= hwdata[7:0];
         if (wr_ob1)
            ob1_r <= hwdata[7:0];
      end
   end

   // Sample bytes once after reset release, then hold until next reset
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sampled_r <= 1'b0;
         lat0_r    <= OB0_DEFAULT;
         lat1_r    <= OB1_DEFAULT;
         first_r   <= 1'b0;
      end
      else
      begin
         first_r   <= ~sampled_r;
         if (!sampled_r)
         begin
            sampled_r <= 1'b1;
            lat0_r    <= ob0_r;
            lat1_r    <= ob1_r;
         end
      end
   end

   // Decoded control outputs
   assign undervoltage_detector_on      = ~lat0_r[OB0_UVD_BIT];
   assign pll_x2_enable                 = ~lat0_r[OB0_PLL_OFF_BIT];
   assign package_select = lat0_r[OB0_PKG_HI_BIT] ? PKG_64 :
                           (lat0_r[OB0_PKG_LO_BIT] ? PKG_44 : PKG_32);
   assign readout_protect_n             = lat0_r[OB0_RDP_N_BIT];
   assign flash_write_block             = ~lat0_r[OB0_RDP_N_BIT] | wiping;
   assign alt_function_remap            = lat1_r[OB1_REMAP1_BIT];
   assign capture2_on_alt_pin           = lat1_r[OB1_REMAP0_BIT];
   assign clock_source_select  = lat1_r[OB1_CLKSRC_HI:OB1_CLKSRC_LO];
   assign in_circuit_programming_mode =
      (lat1_r[OB1_CLKSRC_HI:OB1_CLKSRC_LO] == OBC_SRC_INTERNAL);
   assign resonator_range_select = lat1_r[OB1_RANGE_HI:OB1_RANGE_LO];
   assign reset_delay_select            = lat1_r[OB1_RSTDLY_BIT];
   assign watchdog_reset_on_halt        = lat0_r[OB0_WDG_HALT_BIT];
   assign watchdog_software_enable_mode = lat0_r[OB0_WDG_SW_BIT];
   assign hrdata    = hrdata_r;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // Pad pull-up mask from package code
   obc_pad_mask u_mask
   (
      .pkg_code    (package_select),
      .unbonded_pu (unbonded_pad_pullup)
   );

   // Delay restarts one cycle after the sampling cycle and on every halt exit
   obc_delay u_delay
   (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .start     (first_r | halt_req),
      .short_sel (lat1_r[OB1_RSTDLY_BIT]),
      .busy      (delay_busy)
   );

   // Assertions
   property p_uvd;
      @(posedge hclk) disable iff (!hresetn)
      sampled_r |-> (undervoltage_detector_on == ~lat0_r[OB0_UVD_BIT]);
   endproperty
   a_uvd: assert property (p_uvd) else $error("detector enable wrong");

   property p_pll;
      @(posedge hclk) disable iff (!hresetn)
      pll_x2_enable |-> ~lat0_r[OB0_PLL_OFF_BIT];
   endproperty
   a_pll: assert property (p_pll) else $error("doubler enable wrong");

   property p_pkg;
      @(posedge hclk) disable iff (!hresetn)
      lat0_r[OB0_PKG_HI_BIT] |-> (package_select == PKG_64) && (unbonded_pad_pullup == 48'h0);
   endproperty
   a_pkg: assert property (p_pkg) else $error("package decode wrong");

   property p_pad32;
      @(posedge hclk) disable iff (!hresetn)
      (package_select == PKG_32) |-> (unbonded_pad_pullup[47:32] == 16'hFFFF);
   endproperty
   a_pad32: assert property (p_pad32) else $error("pad pull-up missing");

   property p_prot;
      @(posedge hclk) disable iff (!hresetn)
      (protected_now && wr_ob0 && !wiping) |=> $stable(ob0_r) || (ob0_r == OB_ERASED);
   endproperty
   a_prot: assert property (p_prot) else $error("write under protection");

   property p_wipe;
      @(posedge hclk) disable iff (!hresetn)
      user_mem_erase |=> wiping ##[1:120] (ob0_r == OB_ERASED);
   endproperty
   a_wipe: assert property (p_wipe) else $error("erase sequence wrong");

   property p_remap;
      @(posedge hclk) disable iff (!hresetn)
      (alt_function_remap == lat1_r[OB1_REMAP1_BIT]) &&
      (capture2_on_alt_pin == lat1_r[OB1_REMAP0_BIT]);
   endproperty
   a_remap: assert property (p_remap) else $error("remap wrong");

   property p_hold;
      @(posedge hclk) disable iff (!hresetn)
      sampled_r |=> $stable(lat0_r) && $stable(lat1_r);
   endproperty
   a_hold: assert property (p_hold) else $error("controls changed");

   property p_gate;
      @(posedge hclk) disable iff (!hresetn)
      (acc_read && !prog_mode && ob_addr) |=> (hrdata == 32'h0);
   endproperty
   a_gate: assert property (p_gate) else $error("byte read outside prog");

   property p_dly;
      @(posedge hclk) disable iff (!hresetn)
      (halt_req && reset_delay_select) |=> delay_busy [*8];
   endproperty
   a_dly: assert property (p_dly) else $error("delay too short");

   property p_dlylong;
      @(posedge hclk) disable iff (!hresetn)
      (halt_req && !reset_delay_select) |=> delay_busy [*8];
   endproperty
   a_dlylong: assert property (p_dlylong) else $error("long delay too short");

   property p_samp;
      @(posedge hclk) disable iff (!hresetn)
      $rose(sampled_r) |-> (lat0_r == $past(ob0_r)) && (lat1_r == $past(ob1_r));
   endproperty
   a_samp: assert property (p_samp) else $error("bytes not sampled");

   property p_start;
      @(posedge hclk) disable iff (!hresetn)
      $rose(sampled_r) |=> delay_busy;
   endproperty
   a_start: assert property (p_start) else $error("reset delay not started");

   property p_wblk;
      @(posedge hclk) disable iff (!hresetn)
      wiping |-> flash_write_block;
   endproperty
   a_wblk: assert property (p_wblk) else $error("flash open during wipe");

   property p_icc;
      @(posedge hclk) disable iff (!hresetn)
      in_circuit_programming_mode |-> (clock_source_select == OBC_SRC_INTERNAL);
   endproperty
   a_icc: assert property (p_icc) else $error("internal source flag wrong");

   property p_free;
      @(posedge hclk) disable iff (!hresetn)
      (erase_rq && !protected_now && !wiping) |=> (ob0_r == OB_ERASED) && (ob1_r == OB_ERASED);
   endproperty
   a_free: assert property (p_free) else $error("open erase not at once");

   property p_lock;
      @(posedge hclk) disable iff (!hresetn)
      (wr_pend_r && !prog_mode && !wiping) |=> $stable(ob0_r) && $stable(ob1_r);
   endproperty
   a_lock: assert property (p_lock) else $error("byte written outside prog");

   property p_prot1;
      @(posedge hclk) disable iff (!hresetn)
      (protected_now && wr_ob1 && !wiping) |=> $stable(ob1_r) || (ob1_r == OB_ERASED);
   endproperty
   a_prot1: assert property (p_prot1) else $error("byte 1 write under protection");

   c_wipe: cover property (@(posedge hclk) disable iff (!hresetn) user_mem_erase);
   c_wr:   cover property (@(posedge hclk) disable iff (!hresetn) wr_ob1);
   c_halt: cover property (@(posedge hclk) disable iff (!hresetn) halt_req ##1 delay_busy);
   c_samp: cover property (@(posedge hclk) disable iff (!hresetn) $rose(sampled_r));
   c_lock: cover property (@(posedge hclk) disable iff (!hresetn) protected_now && wr_ob0);
endmodule
`default_nettype wire

// ---- common/obc_pkg.sv ----
// Package of option byte layout, defaults, register map and timing constants
package obc_pkg;
   // Option byte 0 field positions
   localparam int OB0_WDG_HALT_BIT = 7;
   localparam int OB0_WDG_SW_BIT   = 6;
   localparam int OB0_UVD_BIT      = 4;
   localparam int OB0_PLL_OFF_BIT  = 3;
   localparam int OB0_PKG_HI_BIT   = 2;
   localparam int OB0_PKG_LO_BIT   = 1;
   localparam int OB0_RDP_N_BIT    = 0;
   // Option byte 1 field positions
   localparam int OB1_REMAP1_BIT   = 7;
   localparam int OB1_REMAP0_BIT   = 6;
   localparam int OB1_CLKSRC_HI    = 5;
   localparam int OB1_CLKSRC_LO    = 4;
   localparam int OB1_RANGE_HI     = 3;
   localparam int OB1_RANGE_LO     = 2;
   localparam int OB1_RSTDLY_BIT   = 0;
   // Shipped defaults of the two bytes and their erased value
   localparam logic [7:0] OB0_DEFAULT = 8'hFF;
   localparam logic [7:0] OB1_DEFAULT = 8'hEF;
   localparam logic [7:0] OB_ERASED   = 8'hFF;
   // Register byte offsets
   localparam logic [7:0] REG_OB0     = 8'h00;
   localparam logic [7:0] REG_OB1     = 8'h04;
   localparam logic [7:0] REG_CTRL    = 8'h08;
   localparam logic [7:0] REG_STATUS  = 8'h0C;
   localparam logic [7:0] REG_DECODE  = 8'h10;
   // Control register fields
   localparam int CTRL_PROG_BIT    = 0;
   localparam int CTRL_ERASE_BIT   = 1;
   // Reset delay counts in CPU cycles
   localparam logic [12:0] RST_DLY_LONG  = 13'h1000;
   localparam logic [12:0] RST_DLY_SHORT = 13'h0100;
   // User memory erase time and its cycle count at 50 MHz
   localparam int CLK_MHZ        = 50;
   localparam int ERASE_TIME_US  = 2;
   localparam int ERASE_CYCLES   = ERASE_TIME_US * CLK_MHZ;
   // Clock source and range encodings
   typedef enum logic [1:0] {OBC_SRC_RESONATOR, OBC_SRC_RSVD, OBC_SRC_INTERNAL,
                             OBC_SRC_EXTERNAL} obc_src_e;
   typedef enum logic [1:0] {OBC_RNG_1_2, OBC_RNG_2_4, OBC_RNG_4_8,
                             OBC_RNG_8_16} obc_range_e;
   // Package encodings
   localparam logic [1:0] PKG_32 = 2'h0;
   localparam logic [1:0] PKG_44 = 2'h1;
   localparam logic [1:0] PKG_64 = 2'h2;
endpackage

// ---- src/obc_pad_mask.sv ----
// Pull-up mask of pads left unbonded by the selected package
`timescale 1ns/1ns
`default_nettype none
module obc_pad_mask
   import obc_pkg::*;
(
   input  wire logic [1:0]  pkg_code,      // Decoded package code
   output logic      [47:0] unbonded_pu    // One per pad, high when unbonded
);
   import obc_pkg::*;
   // Pads 0..31 always bonded, 32..43 on 44 and 64 pins, 44..47 on 64 only
   assign unbonded_pu = (pkg_code == PKG_64) ? 48'h0000_0000_0000 :
                        (pkg_code == PKG_44) ? 48'hF000_0000_0000 :
                                               48'hFFFF_0000_0000;
endmodule
`default_nettype wire

// ---- src/obc_delay.sv ----
// Reset and halt exit delay counter
`timescale 1ns/1ns
`default_nettype none
module obc_delay
   import obc_pkg::*;
(
   input  wire logic        hclk,        // Clock
   input  wire logic        hresetn,     // Async reset, active low
   input  wire logic        start,       // Pulse to start a delay
   input  wire logic        short_sel,   // High selects the short delay
   output logic             busy         // High while delay runs
);
   import obc_pkg::*;
   logic [12:0] cnt_r;
   wire  [12:0] load_val = short_sel ? RST_DLY_SHORT : RST_DLY_LONG;
   // Counter loads on start, counts down to zero
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         cnt_r <= 13'h0000;
      else if (start)
         cnt_r <= load_val;
      else if (cnt_r != 13'h0000)
         cnt_r <= cnt_r - 13'h0001;
   end
   assign busy = (cnt_r != 13'h0000);
endmodule
`default_nettype wire

// ---- bench/obc_prog_tool.sv ----
// Programming tool model that reaches the option bytes over AHB-Lite
`timescale 1ns/1ns
`default_nettype none
module obc_prog_tool
   import obc_pkg::*;
(
   input  wire logic        hclk,      // Bus clock
   input  wire logic        hready,    // Slave ready
   input  wire logic [31:0] hrdata,    // Read data
   output logic             hsel,      // Slave select
   output logic      [7:0]  haddr,     // Byte address
   output logic      [1:0]  htrans,    // Transfer type
   output logic             hwrite,    // Write when high
   output logic      [2:0]  hsize,     // Always a word
   output logic      [31:0] hwdata,    // Write data
   output logic             prog_mode  // Programming mode pin
);
   // Idle bus at time zero, tool starts outside programming mode
   initial
   begin
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      prog_mode = 1'b0;
   end
   // Bytes are only reached while the mode pin is up
   task automatic set_prog(input logic v);
      @(posedge hclk);
      prog_mode <= v;
   endtask
   // Single word transfer; waits on hready, read data taken at the last edge
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
      // Released lines must not keep their old value
      hsel <= 1'b0;
      haddr <= ~a;
      hwdata <= ~wd;
   endtask
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking testbench of the option byte decoder
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import obc_pkg::*;
   logic        hclk, hresetn, halt_req, hsel, hwrite, prog_mode, hreadyout, hresp;
   logic [7:0]  haddr, lb0, lb1;
   logic [1:0]  htrans, package_select, clock_source_select, resonator_range_select;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, rd;
   logic [47:0] unbonded_pad_pullup;
   logic        undervoltage_detector_on, pll_x2_enable, readout_protect_n;
   logic        flash_write_block, alt_function_remap, capture2_on_alt_pin;
   logic        reset_delay_select, delay_busy, watchdog_reset_on_halt, user_mem_erase;
   logic        watchdog_software_enable_mode, in_circuit_programming_mode;
   int          n_errors, compares, cycles, n_wipe;
   // Byte pairs: doubler only with 2-4 MHz, resonator with long delay
   // External source keeps a matching range in the second pair
   // Bench walks 44, 32 and 64 pin packages, so the unbonded pad pull-ups change
   logic [7:0]  tb0 [4] = '{8'h33, 8'hE9, 8'hFD, 8'hFE};
   logic [7:0]  tb1 [4] = '{8'h06, 8'h7B, 8'h92, 8'hA3};

   obc_prog_tool u_tool (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .prog_mode(prog_mode));
   obc_decoder u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .prog_mode(prog_mode),
      .halt_req(halt_req), .undervoltage_detector_on(undervoltage_detector_on),
      .pll_x2_enable(pll_x2_enable), .package_select(package_select),
      .unbonded_pad_pullup(unbonded_pad_pullup), .readout_protect_n(readout_protect_n),
      .flash_write_block(flash_write_block), .alt_function_remap(alt_function_remap),
      .capture2_on_alt_pin(capture2_on_alt_pin), .clock_source_select(clock_source_select),
      .resonator_range_select(resonator_range_select),
      .reset_delay_select(reset_delay_select), .delay_busy(delay_busy),
      .watchdog_reset_on_halt(watchdog_reset_on_halt),
      .watchdog_software_enable_mode(watchdog_software_enable_mode),
      .user_mem_erase(user_mem_erase),
      .in_circuit_programming_mode(in_circuit_programming_mode));

   // Free running 50 MHz clock
   initial
   begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   // Hang guard, well above the longest delay sequence
   always @(posedge hclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 40000)
      begin
         n_errors++;
         end_sim();
      end
   end
   // Counts wipe pulses off the edge, they end before the bus task returns
   always @(negedge hclk)
      if (user_mem_erase === 1'b1)
         n_wipe <= n_wipe + 1;
   task automatic end_sim();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input string nm, input logic [47:0] s, input logic [47:0] e);
      compares++;
      if (s !== e)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic do_reset();
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
   endtask
   // Counts the cycles of one delay; bounded wait for its start
   task automatic measure(input int len);
      int n;
      int k;
      n = 0;
      k = 0;
      #1;
      while (delay_busy !== 1'b1 && k < 8)
      begin
         @(posedge hclk);
         #1;
         k++;
      end
      while (delay_busy === 1'b1 && n < 5000)
      begin
         n++;
         @(posedge hclk);
         #1;
      end
      check("delay", 48'(n), 48'(len));
   endtask
   // Halt exit restarts the delay
   task automatic halt_exit(input int len);
      @(posedge hclk);
      halt_req <= 1'b1;
      @(posedge hclk);
      halt_req <= 1'b0;
      measure(len);
   endtask
   // Every decoded control against the bytes
   task automatic check_all(input logic [7:0] b0, input logic [7:0] b1);
      logic [1:0]  pk;
      logic [47:0] pads;
      pk = b0[2] ? PKG_64 : (b0[1] ? PKG_44 : PKG_32);
      pads = b0[2] ? 48'h0 : (b0[1] ? 48'hF000_0000_0000 : 48'hFFFF_0000_0000);
      check("uvd", 48'(undervoltage_detector_on), 48'(!b0[4]));
      check("pll", 48'(pll_x2_enable), 48'(!b0[3]));
      check("pkg", 48'(package_select), 48'(pk));
      check("pads", unbonded_pad_pullup, pads);
      check("rdp", 48'(readout_protect_n), 48'(b0[0]));
      check("wblk", 48'(flash_write_block), 48'(!b0[0]));
      check("remap", 48'(alt_function_remap), 48'(b1[7]));
      check("cap2", 48'(capture2_on_alt_pin), 48'(b1[6]));
      check("src", 48'(clock_source_select), 48'(b1[5:4]));
      check("icc", 48'(in_circuit_programming_mode), 48'(b1[5:4] == 2'h2));
      check("range", 48'(resonator_range_select), 48'(b1[3:2]));
      check("reset_delay_select", 48'(reset_delay_select), 48'(b1[0]));
      check("wdh", 48'(watchdog_reset_on_halt), 48'(b0[7]));
      check("wdsw", 48'(watchdog_software_enable_mode), 48'(b0[6]));
      check("hresp", 48'(hresp), 48'h0);
   endtask

   // Main sequence
   initial
   begin
      hresetn = 1'b0;
      halt_req = 1'b0;
      n_errors = 0;
      compares = 0;
      cycles = 0;
      n_wipe = 0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      measure(256);
      check_all(OB0_DEFAULT, OB1_DEFAULT);
      // Outside programming mode the bytes are closed
      u_tool.xfer(1'b1, REG_OB0, 32'h0000_0000, rd);
      u_tool.xfer(1'b0, REG_OB0, 32'h0, rd);
      check("ob0 closed", 48'(rd), 48'h0);
      u_tool.set_prog(1'b1);
      u_tool.xfer(1'b0, REG_OB0, 32'h0, rd);
      check("ob0 kept", 48'(rd), 48'(OB0_DEFAULT));
      u_tool.xfer(1'b0, REG_CTRL, 32'h0, rd);
      check("ctrl mode", 48'(rd[0]), 48'h1);
      u_tool.xfer(1'b0, 8'h20, 32'h0, rd);
      check("unmapped", 48'(rd), 48'h0);
      lb0 = OB0_DEFAULT;
      lb1 = OB1_DEFAULT;
      // New bytes take effect only across a reset
      for (int i = 0; i < 4; i++)
      begin
         // Byte 1 first: once byte 0 turns protection on, byte writes are refused
         u_tool.xfer(1'b1, REG_OB1, {24'h0, tb1[i]}, rd);
         u_tool.xfer(1'b1, REG_OB0, {24'h0, tb0[i]}, rd);
         u_tool.xfer(1'b0, REG_DECODE, 32'h0, rd);
         check("latched", 48'(rd), 48'({lb1, lb0}));
         check_all(lb0, lb1);
         do_reset();
         measure(tb1[i][0] ? 256 : 4096);
         check_all(tb0[i], tb1[i]);
         halt_exit(tb1[i][0] ? 256 : 4096);
         lb0 = tb0[i];
         lb1 = tb1[i];
      end
      // Byte writes refused while protection is on
      u_tool.xfer(1'b1, REG_OB0, 32'h0000_00FF, rd);
      u_tool.xfer(1'b1, REG_OB1, 32'h0000_00FF, rd);
      u_tool.xfer(1'b0, REG_OB0, 32'h0, rd);
      check("ob0 locked", 48'(rd), 48'(tb0[3]));
      u_tool.xfer(1'b0, REG_OB1, 32'h0, rd);
      check("ob1 locked", 48'(rd), 48'(tb1[3]));
      // Erase under protection wipes user memory before the bytes
      u_tool.xfer(1'b1, REG_CTRL, 32'h0000_0002, rd);
      repeat (8) @(posedge hclk);
      check("wipe pulse", 48'(n_wipe), 48'h1);
      check("wipe blk", 48'(flash_write_block), 48'h1);
      repeat (120) @(posedge hclk);
      u_tool.xfer(1'b0, REG_OB0, 32'h0, rd);
      check("ob0 erased", 48'(rd), 48'(OB_ERASED));
      u_tool.xfer(1'b0, REG_OB1, 32'h0, rd);
      check("ob1 erased", 48'(rd), 48'(OB_ERASED));
      do_reset();
      measure(256);
      check_all(OB_ERASED, OB_ERASED);
      // Unprotected erase clears the bytes at once, with no wipe
      u_tool.xfer(1'b1, REG_OB0, 32'h0000_0033, rd);
      u_tool.xfer(1'b1, REG_CTRL, 32'h0000_0002, rd);
      u_tool.xfer(1'b0, REG_OB0, 32'h0, rd);
      check("ob0 erased open", 48'(rd), 48'(OB_ERASED));
      check("no wipe", 48'(n_wipe), 48'h1);
      end_sim();
   end
endmodule
`default_nettype wire
